// >>> design/som_pkg.sv
// package: register map, field layout, reset values and types of the mode control
package som_pkg;

    // ==========================================================
    // register map (byte addresses on the bus)
    localparam logic [7:0] SOM_ADDR_MAIN = 8'h00;
    localparam logic [7:0] SOM_ADDR_AUX = 8'h04;
    localparam int SOM_ADDR_W = 8;

    // ==========================================================
    // main mode register fields
    localparam int SOM_CKS_LSB = 5;
    localparam int SOM_CKS_MSB = 7;
    localparam int SOM_SLOW_RDY_BIT = 3;
    localparam int SOM_FAST_RDY_BIT = 2;
    localparam int SOM_IDLE_EN_BIT = 1;
    localparam int SOM_HIGH_CLK_BIT = 0;

    // ==========================================================
    // aux mode register fields
    localparam int SOM_CLK_KEEP_BIT = 7;
    localparam int SOM_LVR_FLAG_BIT = 2;
    localparam int SOM_WDT_FLAG_BIT = 0;

    // ==========================================================
    // reset values
    localparam logic [2:0] SOM_CKS_RST = 3'h6;
    localparam logic SOM_IDLE_EN_RST = 1'b1;
    localparam logic SOM_HIGH_CLK_RST = 1'b0;
    localparam logic SOM_CLK_KEEP_RST = 1'b0;
    localparam logic SOM_LVR_FLAG_RST = 1'b0;
    localparam logic SOM_WDT_FLAG_RST = 1'b0;

    // ==========================================================
    // divider encoding: codes up to this one pick the slow clock
    localparam logic [2:0] SOM_CKS_SLOW_MAX = 3'h1;
    localparam logic [2:0] SOM_CKS_DIV_BASE = 3'h2;
    localparam logic [6:0] SOM_DIV_TOP = 7'h40;
    localparam int SOM_DIV_W = 6;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        SOM_RUN,
        SOM_SLEEP,
        SOM_IDLE_STOP,
        SOM_IDLE_RUN
    } som_state_t;

    typedef struct packed {
        logic cpu_run;
        logic sys_clk_run;
        logic tbc_run;
        logic fast_osc_en;
        logic slow_src;
    } som_ctrl_t;

    typedef struct packed {
        logic wdt_clear;
        logic pdf_set;
        logic to_clear;
    } som_halt_evt_t;

endpackage

// >>> design/som_sync3.sv
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none
module som_sync3 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // levels
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    // ==========================================================
    // per-bit chain; stage one feeds only stage two
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1_ff;
            logic s2_ff;
            logic s3_ff;
            logic out_ff;
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    s1_ff <= 1'b0;
                    s2_ff <= 1'b0;
                    s3_ff <= 1'b0;
                    out_ff <= 1'b0;
                end else begin
                    s1_ff <= din[i];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                    // a change counts once stages two and three agree
                    if (s2_ff == s3_ff) begin
                        out_ff <= s3_ff;
                    end
                end
            end
            assign dout[i] = out_ff;
        end
    endgenerate

endmodule // som_sync3
`default_nettype wire

// >>> design/som_mode_ctrl.sv
// system clock source and operating mode controller with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
module som_mode_ctrl
    import som_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // oscillator pins
    input wire logic fast_osc_stable,
    input wire logic slow_osc_stable,
    input wire logic slow_rc_osc,
    // processor core
    input wire logic halt_instr,
    input wire logic wake_req,
    // reset cause events
    input wire logic lvr_event,
    input wire logic wdt_reg_reset_event,
    // clock and mode outputs
    output som_pkg::som_ctrl_t ctrl,
    output som_pkg::som_halt_evt_t halt_evt,
    output logic sys_clk_tick
);
    import som_pkg::*;

    // ==========================================================
    // state
    som_state_t state_ff, nxt_state;
    logic [2:0] cks_ff;
    logic idle_en_ff;
    logic high_clk_ff;
    logic clk_keep_ff;
    logic lvr_flag_ff;
    logic wdt_flag_ff;
    logic wr_pend_ff;
    logic [SOM_ADDR_W-1:0] wr_addr_ff;
    logic [31:0] hrdata_ff;
    logic slow_active_ff;
    logic cur_high_ff;
    logic [2:0] cur_cks_ff;
    logic [SOM_DIV_W-1:0] div_cnt_ff;
    logic slow_prev_ff;
    som_ctrl_t ctrl_ff, nxt_ctrl;
    som_halt_evt_t halt_evt_ff, nxt_halt_evt;
    logic tick_ff;

    // ==========================================================
    // pin synchronisers
    logic [2:0] pins_sync;
    som_sync3 #(.WIDTH(3)) u_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .din({slow_rc_osc, slow_osc_stable, fast_osc_stable}),
        .dout(pins_sync)
    );
    wire fast_rdy = pins_sync[0];
    wire slow_rdy = pins_sync[1];
    wire slow_lvl = pins_sync[2];
    wire slow_rise = slow_lvl && !slow_prev_ff;

    // ==========================================================
    // bus decode
    wire [SOM_ADDR_W-1:0] addr_lo = haddr[SOM_ADDR_W-1:0];
    wire addr_phase = hsel && htrans[1] && hready;
    wire wr_main = wr_pend_ff && (wr_addr_ff == SOM_ADDR_MAIN);
    wire wr_aux = wr_pend_ff && (wr_addr_ff == SOM_ADDR_AUX);
    wire [7:0] main_rd = {cks_ff, 1'b0, slow_rdy, fast_rdy,
                          idle_en_ff, high_clk_ff};
    wire [7:0] aux_rd = {clk_keep_ff, 4'h0, lvr_flag_ff, 1'b0,
                         wdt_flag_ff};
    wire [31:0] rd_mux = (addr_lo == SOM_ADDR_MAIN) ? {24'h0, main_rd} :
                         (addr_lo == SOM_ADDR_AUX) ? {24'h0, aux_rd} :
                         32'h0;
    wire [31:0] nxt_hrdata = (addr_phase && !hwrite) ? rd_mux : 32'h0;

    // ==========================================================
    // register write data
    wire [2:0] nxt_cks = wr_main ? hwdata[SOM_CKS_MSB:SOM_CKS_LSB] : cks_ff;
    wire nxt_idle_en = wr_main ? hwdata[SOM_IDLE_EN_BIT] : idle_en_ff;
    wire nxt_high_clk = wr_main ? hwdata[SOM_HIGH_CLK_BIT] : high_clk_ff;
    wire nxt_clk_keep = wr_aux ? hwdata[SOM_CLK_KEEP_BIT] : clk_keep_ff;
    // hardware set wins over a software clear in the same cycle
    wire nxt_lvr_flag = lvr_event ? 1'b1 :
                        wr_aux ? hwdata[SOM_LVR_FLAG_BIT] : lvr_flag_ff;
    wire nxt_wdt_flag = wdt_reg_reset_event ? 1'b1 :
                        wr_aux ? hwdata[SOM_WDT_FLAG_BIT] : wdt_flag_ff;

    // ==========================================================
    // clock source selection and divider
    wire want_slow = !high_clk_ff && (cks_ff <= SOM_CKS_SLOW_MAX);
    wire [2:0] div_sh = cur_cks_ff - SOM_CKS_DIV_BASE;
    wire [6:0] div_ratio = SOM_DIV_TOP >> div_sh;
    wire [SOM_DIV_W-1:0] div_max = cur_high_ff ? '0 :
                                   SOM_DIV_W'(div_ratio - 7'h1);
    wire fast_bound = (div_cnt_ff == div_max);
    // a new source is only taken where the running clock ends a period
    wire boundary = slow_active_ff ? slow_rise : fast_bound;
    wire go_slow = boundary && want_slow && slow_rdy;
    wire go_fast = boundary && !want_slow && (!slow_active_ff || fast_rdy);
    wire nxt_slow_active = go_slow ? 1'b1 : go_fast ? 1'b0 : slow_active_ff;
    wire [SOM_DIV_W-1:0] nxt_div_cnt =
        (boundary || slow_active_ff) ? '0 : div_cnt_ff + 1'b1;

    // ==========================================================
    // operating mode
    wire halt_go = (state_ff == SOM_RUN) && halt_instr;
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            SOM_RUN: begin
                if (halt_instr) begin
                    if (!idle_en_ff) begin
                        nxt_state = SOM_SLEEP;
                    end else if (!clk_keep_ff) begin
                        nxt_state = SOM_IDLE_STOP;
                    end else begin
                        nxt_state = SOM_IDLE_RUN;
                    end
                end
            end
            SOM_SLEEP, SOM_IDLE_STOP, SOM_IDLE_RUN: begin
                if (wake_req) begin
                    nxt_state = SOM_RUN;
                end
            end
        endcase
    end

    wire nxt_run = (nxt_state == SOM_RUN);
    wire nxt_sys_on = nxt_run || (nxt_state == SOM_IDLE_RUN);
    always_comb begin
        nxt_ctrl.cpu_run = nxt_run;
        nxt_ctrl.sys_clk_run = nxt_sys_on;
        nxt_ctrl.tbc_run = (nxt_state != SOM_SLEEP);
        // the fast oscillator idles once slow runs and slow is wanted
        nxt_ctrl.fast_osc_en = nxt_sys_on &&
                               !(nxt_slow_active && want_slow);
        nxt_ctrl.slow_src = nxt_slow_active;
        nxt_halt_evt.wdt_clear = halt_go;
        nxt_halt_evt.pdf_set = halt_go;
        nxt_halt_evt.to_clear = halt_go;
    end
    wire nxt_tick = boundary && (state_ff == SOM_RUN ||
                                 state_ff == SOM_IDLE_RUN);

    // ==========================================================
    // flops
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cks_ff <= SOM_CKS_RST;
            idle_en_ff <= SOM_IDLE_EN_RST;
            high_clk_ff <= SOM_HIGH_CLK_RST;
            clk_keep_ff <= SOM_CLK_KEEP_RST;
            lvr_flag_ff <= SOM_LVR_FLAG_RST;
            wdt_flag_ff <= SOM_WDT_FLAG_RST;
        end else begin
            cks_ff <= nxt_cks;
            idle_en_ff <= nxt_idle_en;
            high_clk_ff <= nxt_high_clk;
            clk_keep_ff <= nxt_clk_keep;
            lvr_flag_ff <= nxt_lvr_flag;
            wdt_flag_ff <= nxt_wdt_flag;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= '0;
            hrdata_ff <= 32'h0;
        end else begin
            wr_pend_ff <= addr_phase && hwrite;
            wr_addr_ff <= addr_lo;
            hrdata_ff <= nxt_hrdata;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            slow_active_ff <= 1'b0;
            cur_high_ff <= SOM_HIGH_CLK_RST;
            cur_cks_ff <= SOM_CKS_RST;
            div_cnt_ff <= '0;
            slow_prev_ff <= 1'b0;
        end else begin
            slow_active_ff <= nxt_slow_active;
            if (go_fast) begin
                cur_high_ff <= high_clk_ff;
                cur_cks_ff <= cks_ff;
            end
            div_cnt_ff <= nxt_div_cnt;
            slow_prev_ff <= slow_lvl;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= SOM_RUN;
            ctrl_ff <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
            halt_evt_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ctrl_ff <= nxt_ctrl;
            halt_evt_ff <= nxt_halt_evt;
            tick_ff <= nxt_tick;
        end
    end

    // ==========================================================
    // outputs
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign ctrl = ctrl_ff;
    assign halt_evt = halt_evt_ff;
    assign sys_clk_tick = tick_ff;

    // ==========================================================
    // assertions
    sequence halt_seen_s;
        state_ff == SOM_RUN && halt_instr && !wake_req;
    endsequence
    sequence halted_one_s;
        !ctrl.cpu_run && halt_evt.pdf_set && halt_evt.wdt_clear;
    endsequence

    sleep_entry_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        halt_seen_s and !idle_en_ff |=> halted_one_s ##0
        (!ctrl.sys_clk_run && !ctrl.tbc_run && !ctrl.fast_osc_en))
        else $error("sleep entry did not stop clocks");

    idle_stop_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        halt_seen_s and idle_en_ff && !clk_keep_ff |=> halted_one_s ##0
        (!ctrl.sys_clk_run && ctrl.tbc_run))
        else $error("idle stopped entry wrong");

    idle_run_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        halt_seen_s and idle_en_ff && clk_keep_ff |=> halted_one_s ##0
        (ctrl.sys_clk_run && ctrl.tbc_run))
        else $error("idle running entry wrong");

    halt_pulse_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        halt_evt.pdf_set |=> !halt_evt.pdf_set && !halt_evt.to_clear)
        else $error("halt event longer than one cycle");

    fast_stop_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        $rose(slow_active_ff) && want_slow |-> !ctrl.fast_osc_en)
        else $error("fast oscillator left on in slow mode");

    slow_ready_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        $rose(slow_active_ff) |-> $past(slow_rdy))
        else $error("slow source taken before ready");

    no_tick_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (state_ff == SOM_IDLE_STOP)[*2] |-> !sys_clk_tick)
        else $error("system clock ticks while stopped");

    div_period_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        fast_bound && !slow_active_ff && !cur_high_ff && cur_cks_ff == 3'h7
        && !want_slow && high_clk_ff == cur_high_ff && cks_ff == 3'h7
        |=> !fast_bound ##1 fast_bound)
        else $error("divide by two period wrong");

    rsvd_zero_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        addr_phase && !hwrite |=> hrdata[31:8] == 24'h0 &&
        ($past(addr_lo) != SOM_ADDR_AUX || hrdata[6:3] == 4'h0))
        else $error("reserved bits not zero");

    flag_set_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        wdt_reg_reset_event |=> wdt_flag_ff)
        else $error("watchdog register flag not set");

endmodule // som_mode_ctrl
`default_nettype wire

// >>> testbench/som_osc_model.sv
// oscillator model: free-running slow rc waveform and stability pins
`timescale 1ns/1ps
`default_nettype none
module som_osc_model #(
    parameter int SLOW_HALF_NS = 310,
    parameter int STABLE_NS = 1600
) (
    // reset of the system
    input wire logic resetn,
    // oscillator pins
    output logic slow_rc_osc,
    output logic fast_osc_stable,
    output logic slow_osc_stable
);
    // ==========================================================
    // slow oscillator
    // half period is not a multiple of the core period, so the edges drift
    // against core_clk and the synchroniser sees edges at four phases 10 ns apart
    initial slow_rc_osc = 1'b0;
    always #(SLOW_HALF_NS) slow_rc_osc = ~slow_rc_osc;

    // ==========================================================
    // stability after reset release
    // late on purpose: the first register reads and the first slow switch
    // request land before either oscillator is reported stable
    initial begin
        fast_osc_stable = 1'b0;
        slow_osc_stable = 1'b0;
        wait (resetn === 1'b1);
        #(STABLE_NS);
        fast_osc_stable = 1'b1;
        slow_osc_stable = 1'b1;
    end
endmodule // som_osc_model
`default_nettype wire

// >>> testbench/tb_system_operating_mode_control.sv
// testbench: registers, clock selection and halt modes of the mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_system_operating_mode_control;
    import som_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic halt_instr = 1'b0;
    logic wake_req = 1'b0;
    logic lvr_event = 1'b0;
    logic wdt_ev = 1'b0;
    wire logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic fast_st, slow_st, slow_osc;
    som_ctrl_t ctrl;
    som_halt_evt_t halt_evt;
    logic sys_clk_tick;
    int num_errors = 0;
    int cmp_count = 0;
    logic [31:0] rd_q[$];
    logic [7:0] hlt_q[$];
    logic rd_dp = 1'b0;
    int p, n;
    logic [31:0] d;

    assign hready = hreadyout;
    always #20 core_clk = ~core_clk;

    som_osc_model osc (.resetn(resetn), .slow_rc_osc(slow_osc),
        .fast_osc_stable(fast_st), .slow_osc_stable(slow_st));
    som_mode_ctrl dut (.core_clk(core_clk), .resetn(resetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .fast_osc_stable(fast_st),
        .slow_osc_stable(slow_st), .slow_rc_osc(slow_osc),
        .halt_instr(halt_instr), .wake_req(wake_req), .lvr_event(lvr_event),
        .wdt_reg_reset_event(wdt_ev), .ctrl(ctrl), .halt_evt(halt_evt),
        .sys_clk_tick(sys_clk_tick));

    // ==========================================================
    // comparison and verdict
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================================
    // ahb-lite master: one idle edge before each address phase
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do begin @(posedge core_clk); k++; end
        while (hready !== 1'b1 && k < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        k = 0;
        do begin @(posedge core_clk); k++; end
        while (hready !== 1'b1 && k < 50);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        bus(1'b1, a, wd);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        bus(1'b0, a, 32'h0);
    endtask

    // ==========================================================
    // system clock tick helpers
    task automatic wait_tick;
        int k;
        k = 0;
        do begin @(posedge core_clk); k++; end
        while (sys_clk_tick !== 1'b1 && k < 500);
    endtask

    task automatic measure(output int per);
        wait_tick;
        wait_tick;
        per = 0;
        do begin @(posedge core_clk); per++; end
        while (sys_clk_tick !== 1'b1 && per < 500);
    endtask

    // halt in one mode, watch the clock, then wake
    task automatic halt_case(input logic idle, input logic keep,
                             input logic [4:0] exp_ctrl);
        int ticks;
        wr(SOM_ADDR_MAIN, {24'h0, 3'h7, 3'h0, idle, 1'b0});
        wr(SOM_ADDR_AUX, {24'h0, keep, 7'h0});
        wait_tick;
        hlt_q.push_back({exp_ctrl, 3'b111});
        @(posedge core_clk);
        halt_instr <= 1'b1;
        @(posedge core_clk);
        halt_instr <= 1'b0;
        repeat (2) @(posedge core_clk);
        ticks = 0;
        repeat (20) begin
            @(posedge core_clk);
            if (sys_clk_tick === 1'b1) ticks++;
        end
        check("halt_ticks", 32'(ticks != 0), 32'(idle & keep));
        @(posedge core_clk);
        wake_req <= 1'b1;
        @(posedge core_clk);
        wake_req <= 1'b0;
        @(posedge core_clk);
        check("cpu_run", 32'(ctrl.cpu_run), 32'h1);
        $display("test halt idle=%0d keep=%0d done", idle, keep);
    endtask

    // ==========================================================
    // output monitor: read data phases and halt events
    always @(posedge core_clk) begin
        if (rd_dp && hready === 1'b1)
            check("hrdata", hrdata, rd_q.pop_front());
        rd_dp <= hsel && htrans[1] && !hwrite && hready;
        if (halt_evt !== 3'b000)
            check("ctrl_evt", 32'({ctrl, halt_evt}), 32'(hlt_q.pop_front()));
        if (hresp !== 1'b0)
            check("hresp", 32'(hresp), 32'h0);
    end

    // watchdog well above the expected run of under 1000 cycles
    initial begin
        #(40 * 30000);
        num_errors++;
        $display("watchdog expired");
        stop_test;
    end

    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(82));
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        rd(SOM_ADDR_MAIN, 32'hc2);
        rd(SOM_ADDR_AUX, 32'h00);
        wr(SOM_ADDR_MAIN, 32'h02);
        repeat (5) @(posedge core_clk);
        check("early_slow", 32'(ctrl.slow_src), 32'h0);
        $display("test reset values done");
        n = 0;
        do begin @(posedge core_clk); n++; end
        while (ctrl.slow_src !== 1'b1 && n < 200);
        check("slow_src", 32'(ctrl.slow_src), 32'h1);
        check("fast_en", 32'(ctrl.fast_osc_en), 32'h0);
        check("run_tbc", 32'({ctrl.cpu_run, ctrl.tbc_run}), 32'h3);
        rd(SOM_ADDR_MAIN, 32'h0e);
        $display("test slow mode done");
        repeat (4) begin
            d = $urandom;
            wr(SOM_ADDR_AUX, d);
            rd(SOM_ADDR_AUX, d & 32'h85);
            d = $urandom;
            wr(SOM_ADDR_MAIN, d);
            rd(SOM_ADDR_MAIN, (d & 32'he3) | 32'h0c);
        end
        wr(SOM_ADDR_AUX, 32'h0);
        @(posedge core_clk);
        lvr_event <= 1'b1;
        wdt_ev <= 1'b1;
        @(posedge core_clk);
        lvr_event <= 1'b0;
        wdt_ev <= 1'b0;
        repeat (8) @(posedge core_clk);
        rd(SOM_ADDR_AUX, 32'h05);
        wr(8'h08, 32'hff);
        rd(8'h08, 32'h0);
        $display("test registers done");
        for (int c = 2; c < 8; c++) begin
            wr(SOM_ADDR_MAIN, 32'(c << 5) | 32'h2);
            measure(p);
            check("period", 32'(p), 32'(64 >> (c - 2)));
        end
        wr(SOM_ADDR_MAIN, 32'h03);
        measure(p);
        check("period_fast", 32'(p), 32'h1);
        $display("test divider done");
        halt_case(1'b0, 1'b0, 5'b00000);
        halt_case(1'b1, 1'b0, 5'b00100);
        halt_case(1'b1, 1'b1, 5'b01110);
        check("evt_left", 32'(hlt_q.size()), 32'h0);
        stop_test;
    end
endmodule // tb_system_operating_mode_control
`default_nettype wire
